// >>> shared/sbt_pkg.sv
// Shared constants and types for the sequential break and trace capture block.
package sbt_pkg;

  // APB register byte offsets.
  localparam logic [7:0] OFF_CTRL     = 8'h00;
  localparam logic [7:0] OFF_STATUS   = 8'h04;
  localparam logic [7:0] OFF_WA_START = 8'h08;
  localparam logic [7:0] OFF_WA_END   = 8'h0C;
  localparam logic [7:0] OFF_WB_START = 8'h10;
  localparam logic [7:0] OFF_WB_END   = 8'h14;
  localparam logic [7:0] OFF_BT_INDEX = 8'h18;
  localparam logic [7:0] OFF_BT_SRC   = 8'h1C;
  localparam logic [7:0] OFF_BT_DST   = 8'h20;
  localparam logic [7:0] OFF_BT_COUNT = 8'h24;
  localparam logic [7:0] OFF_IO_ADDR  = 8'h28;
  localparam logic [7:0] OFF_IO_DATA  = 8'h2C;
  localparam logic [7:0] OFF_TLB_PC   = 8'h30;

  // Control register field positions.
  localparam int CTRL_ARM_LO  = 0;
  localparam int CTRL_ARM_HI  = 3;
  localparam int CTRL_NONRT   = 4;
  localparam int CTRL_STOP    = 5;
  localparam int CTRL_CONT    = 6;
  localparam int CTRL_BR_EN   = 7;
  localparam int CTRL_WA_EN   = 8;
  localparam int CTRL_WB_EN   = 9;
  localparam int CTRL_SW_EN   = 10;
  localparam int CTRL_WA_MODE = 11;
  localparam int CTRL_WB_MODE = 13;
  localparam int CTRL_W       = 15;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 15'h0000;

  // Status register field positions.
  localparam int ST_HALT = 0;
  localparam int ST_DROP = 1;
  localparam int ST_FULL = 2;
  localparam int ST_BUSY = 3;

  // Window cycle select bits: read qualifies, write qualifies.
  localparam int MODE_RD = 0;
  localparam int MODE_WR = 1;

  // Sequences: highest and lowest break condition index of each chain.
  localparam int SEQ_N = 4;
  localparam int SEQ_HI [SEQ_N] = '{1, 2, 3, 5};
  localparam int SEQ_LO [SEQ_N] = '{0, 0, 0, 4};

  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;

  typedef enum logic [1:0] {AUX_BRANCH, AUX_WIN_A, AUX_WIN_B, AUX_SW} sbt_aux_t;
  typedef enum logic [1:0] {LEN_4, LEN_8, LEN_16, LEN_32} sbt_len_t;

endpackage

// >>> design/sbt_seq_break.sv
// Ordered break-condition sequence detector for one chain of stages.
module sbt_seq_break
  import sbt_pkg::*;
#(
  parameter int STAGES = 2
)(
  input  wire logic              clk,
  input  wire logic              rstn,
  input  wire logic              arm,
  input  wire logic [STAGES-1:0] cond,
  output logic                   hit
);
  localparam int SW = $clog2(STAGES);
  localparam logic [SW-1:0] LAST = SW'(STAGES - 1);

  logic [SW-1:0] stage;
  logic [SW-1:0] next_stage;
  logic          armQ;
  logic          next_armQ;

  // Stage s waits for cond[STAGES-1-s]; the top bit is the first condition.
  always_comb
  begin
    next_stage = stage;
    next_armQ  = arm;
    hit        = 1'b0;
    if (!arm || !armQ)
      next_stage = '0;
    else if (cond[LAST - stage])
    begin
      if (stage == LAST)
      begin
        hit        = 1'b1;
        next_stage = '0;
      end
      else
        next_stage = stage + 1'b1;
    end
  end

  // Progress registers.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      stage <= '0;
      armQ  <= 1'b0;
    end
    else
    begin
      stage <= next_stage;
      armQ  <= next_armQ;
    end
  end

  property p_rearm;
    @(posedge clk) disable iff (!rstn) arm && !armQ |=> stage == '0;
  endproperty
  a_rearm: assert property (p_rearm) else $error("Re-arm did not clear progress.");

  property p_order;
    @(posedge clk) disable iff (!rstn)
      arm && armQ && stage == '0 && cond[LAST] && !hit |=> stage == SW'(1);
  endproperty
  a_order: assert property (p_order) else $error("First condition did not advance.");
endmodule

// >>> design/sbt_debug_top.sv
// Sequential break, internal trace store and aux trace port record source.
// How it works
// - Chain 2-1 halts only when condition 2 then condition 1 match.
// - Chain 3-2-1 halts only after conditions 3, 2, 1 in order.
// - Chain 4-3-2-1 halts only after conditions 4, 3, 2, 1 in order.
// - Chain 6-5 halts only when condition 6 then condition 5 match.
// - Realtime mode: busy port drops the new branch record, CPU never stalls.
// - Non-realtime mode: busy port stalls the CPU until the slot frees.
// - Internal store keeps eight latest branches, up to 32 in continuous mode.
// - Internal I/O and TLB-load traces stay internal, never on the aux port.
// - Two address windows, A and B, each with start and end.
// - Each window qualifies reads, writes, or both.
// - Each window has its own enable and captures only while enabled.
// - Each branch record carries source and destination address.
// - Software trace records the instruction's PC and one register value.
// - Branch source is sent as its low 4, 8 or 16 bits when upper bits match.
// - Conditions 5 and 6 come from the user break unit, apart from 1 to 4.
//
// The implementer's own choices: the APB interface to the registers and the address map.
module sbt_debug_top
  import sbt_pkg::*;
#(
  parameter int BT_BASE  = 8,
  parameter int BT_DEPTH = 32
)(
  input  wire logic              clk,
  input  wire logic              rstn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [DATA_W-1:0] pwdata,
  output logic                   pready,
  output logic [DATA_W-1:0]      prdata,
  output logic                   pslverr,
  input  wire logic [3:0]        brkCond,
  input  wire logic [1:0]        userBreakCond,
  input  wire logic              branchValid,
  input  wire logic [ADDR_W-1:0] branchSrc,
  input  wire logic [ADDR_W-1:0] branchDst,
  input  wire logic              busValid,
  input  wire logic              busWrite,
  input  wire logic [ADDR_W-1:0] busAddr,
  input  wire logic [DATA_W-1:0] busData,
  input  wire logic              swTraceValid,
  input  wire logic [ADDR_W-1:0] swTracePc,
  input  wire logic [DATA_W-1:0] swTraceReg,
  input  wire logic              ioValid,
  input  wire logic [ADDR_W-1:0] ioAddr,
  input  wire logic [DATA_W-1:0] ioData,
  input  wire logic              tlbLoadValid,
  input  wire logic [ADDR_W-1:0] tlbLoadPc,
  input  wire logic              auxReady,
  output logic                   haltReq,
  output logic                   cpuStall,
  output logic                   auxValid,
  output sbt_aux_t               auxType,
  output sbt_len_t               auxLen,
  output logic [2*DATA_W-1:0]    auxData
);
  localparam int PW = $clog2(BT_DEPTH);
  localparam int CW = PW + 1;

  // Inclusive window match with read/write qualification.
  function automatic logic winMatch(input logic [ADDR_W-1:0] a, s, e,
                                    input logic [1:0] mode, input logic wr);
    return (a >= s) && (a <= e) && (wr ? mode[MODE_WR] : mode[MODE_RD]);
  endfunction

  // Shortest length whose upper bits match the previous source.
  function automatic sbt_len_t srcLen(input logic [ADDR_W-1:0] n, p);
    if (n[31:4] == p[31:4])
      return LEN_4;
    else if (n[31:8] == p[31:8])
      return LEN_8;
    else if (n[31:16] == p[31:16])
      return LEN_16;
    return LEN_32;
  endfunction

  logic [CTRL_W-1:0] ctrl, next_ctrl;
  logic [ADDR_W-1:0] waStart, waEnd, wbStart, wbEnd;
  logic [ADDR_W-1:0] next_waStart, next_waEnd, next_wbStart, next_wbEnd;
  logic [PW-1:0]     btIdx, next_btIdx;
  logic              dropFlag, next_dropFlag, next_haltReq;
  logic              next_pready, next_pslverr;
  logic [DATA_W-1:0] next_prdata;
  logic              wrEn, setup;

  wire logic       nonRt  = ctrl[CTRL_NONRT];
  wire logic       cont   = ctrl[CTRL_CONT];
  wire logic       brEn   = ctrl[CTRL_BR_EN];
  wire logic [1:0] waMode = ctrl[CTRL_WA_MODE +: 2];
  wire logic [1:0] wbMode = ctrl[CTRL_WB_MODE +: 2];

  // Break conditions 1..6; 5 and 6 arrive from the user break unit.
  wire logic [5:0] allCond = {userBreakCond, brkCond};
  logic [SEQ_N-1:0] seqHit;

  // One ordered detector per sequence chain.
  generate
    for (genvar g = 0; g < SEQ_N; g++)
    begin : g_seq
      sbt_seq_break #(.STAGES(SEQ_HI[g] - SEQ_LO[g] + 1)) u_seq (
        .clk  (clk),
        .rstn (rstn),
        .arm  (ctrl[CTRL_ARM_LO + g]),
        .cond (allCond[SEQ_HI[g]:SEQ_LO[g]]),
        .hit  (seqHit[g])
      );
    end
  endgenerate

  // Aux record slot: priority branch, window A, window B, software trace.
  logic slotFree, branchGo, winAHit, winBHit, swHit;
  logic next_auxValid, next_cpuStall;
  sbt_aux_t next_auxType;
  sbt_len_t next_auxLen;
  logic [2*DATA_W-1:0] next_auxData;
  logic [ADDR_W-1:0] lastSrc, next_lastSrc;

  always_comb
  begin
    slotFree = !auxValid || auxReady;
    branchGo = branchValid && brEn && (slotFree || !nonRt);
    winAHit  = ctrl[CTRL_WA_EN] && busValid
               && winMatch(busAddr, waStart, waEnd, waMode, busWrite);
    winBHit  = ctrl[CTRL_WB_EN] && busValid
               && winMatch(busAddr, wbStart, wbEnd, wbMode, busWrite);
    swHit    = ctrl[CTRL_SW_EN] && swTraceValid;
    next_auxValid = auxValid && !auxReady;
    next_auxType  = auxType;
    next_auxLen   = auxLen;
    next_auxData  = auxData;
    next_lastSrc  = lastSrc;
    next_cpuStall = nonRt && branchValid && brEn && !slotFree;
    // A write of one clears the drop flag; a drop later in this process still wins.
    next_dropFlag = dropFlag && !(wrEn && paddr == OFF_STATUS && pwdata[ST_DROP]);
    if (slotFree)
    begin
      if (branchGo)
      begin
        next_auxValid = 1'b1;
        next_auxType  = AUX_BRANCH;
        next_auxLen   = srcLen(branchSrc, lastSrc);
        next_auxData  = {branchDst, branchSrc};
        next_lastSrc  = branchSrc;
      end
      else if (winAHit || winBHit)
      begin
        next_auxValid = 1'b1;
        next_auxType  = winAHit ? AUX_WIN_A : AUX_WIN_B;
        next_auxLen   = LEN_32;
        next_auxData  = {busData, busAddr};
      end
      else if (swHit)
      begin
        next_auxValid = 1'b1;
        next_auxType  = AUX_SW;
        next_auxLen   = LEN_32;
        next_auxData  = {swTraceReg, swTracePc};
      end
    end
    else if (branchGo)
      next_dropFlag = 1'b1;
  end

  // Aux port and stall registers.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      auxValid <= 1'b0;
      auxType  <= AUX_BRANCH;
      auxLen   <= LEN_32;
      auxData  <= '0;
      lastSrc  <= '0;
      cpuStall <= 1'b0;
      dropFlag <= 1'b0;
    end
    else
    begin
      auxValid <= next_auxValid;
      auxType  <= next_auxType;
      auxLen   <= next_auxLen;
      auxData  <= next_auxData;
      lastSrc  <= next_lastSrc;
      cpuStall <= next_cpuStall;
      dropFlag <= next_dropFlag;
    end
  end

  // Internal branch store: eight-entry ring, or up to 32 in continuous mode.
  logic [ADDR_W-1:0] btSrc [BT_DEPTH];
  logic [ADDR_W-1:0] btDst [BT_DEPTH];
  logic [PW-1:0]     wrPtr, next_wrPtr;
  logic [CW-1:0]     btCount, next_btCount, limit;
  logic              storeFull, capture;

  always_comb
  begin
    limit        = cont ? CW'(BT_DEPTH) : CW'(BT_BASE);
    storeFull    = btCount >= limit;
    capture      = branchGo && !(storeFull && cont && ctrl[CTRL_STOP]);
    next_wrPtr   = wrPtr;
    next_btCount = btCount;
    if (capture)
    begin
      next_wrPtr = (CW'(wrPtr) + 1'b1 >= limit) ? '0 : wrPtr + 1'b1;
      if (!storeFull)
        next_btCount = btCount + 1'b1;
    end
  end

  // Store pointer registers.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      wrPtr   <= '0;
      btCount <= '0;
    end
    else
    begin
      wrPtr   <= next_wrPtr;
      btCount <= next_btCount;
    end
  end

  // Store contents are written in place by index.
  always_ff @(posedge clk)
  begin
    if (capture)
    begin
      btSrc[wrPtr] <= branchSrc;
      btDst[wrPtr] <= branchDst;
    end
  end

  // Internal-only I/O and TLB-load capture.
  logic [ADDR_W-1:0] ioAddrQ, tlbPcQ;
  logic [DATA_W-1:0] ioDataQ;
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ioAddrQ <= '0;
      ioDataQ <= '0;
      tlbPcQ  <= '0;
    end
    else
    begin
      if (ioValid && cont)
      begin
        ioAddrQ <= ioAddr;
        ioDataQ <= ioData;
      end
      if (tlbLoadValid && cont)
        tlbPcQ <= tlbLoadPc;
    end
  end

  // APB slave: setup loads read data, one access cycle completes.
  always_comb
  begin
    setup        = psel && !penable;
    wrEn         = psel && penable && pready && pwrite;
    next_pready  = setup;
    next_pslverr = 1'b0;
    next_prdata  = '0;
    next_ctrl    = ctrl;
    next_waStart = waStart;
    next_waEnd   = waEnd;
    next_wbStart = wbStart;
    next_wbEnd   = wbEnd;
    next_btIdx   = btIdx;
    unique case (paddr)
      OFF_CTRL:     next_prdata = DATA_W'(ctrl);
      OFF_STATUS:   next_prdata = DATA_W'({auxValid, storeFull, dropFlag, haltReq});
      OFF_WA_START: next_prdata = waStart;
      OFF_WA_END:   next_prdata = waEnd;
      OFF_WB_START: next_prdata = wbStart;
      OFF_WB_END:   next_prdata = wbEnd;
      OFF_BT_INDEX: next_prdata = DATA_W'(btIdx);
      OFF_BT_SRC:   next_prdata = btSrc[btIdx];
      OFF_BT_DST:   next_prdata = btDst[btIdx];
      OFF_BT_COUNT: next_prdata = DATA_W'(btCount);
      OFF_IO_ADDR:  next_prdata = ioAddrQ;
      OFF_IO_DATA:  next_prdata = ioDataQ;
      OFF_TLB_PC:   next_prdata = tlbPcQ;
      default:      next_pslverr = setup;
    endcase
    if (!setup || pwrite)
      next_prdata = prdata;
    if (wrEn)
    begin
      unique case (paddr)
        OFF_CTRL:     next_ctrl    = pwdata[CTRL_W-1:0];
        OFF_WA_START: next_waStart = pwdata;
        OFF_WA_END:   next_waEnd   = pwdata;
        OFF_WB_START: next_wbStart = pwdata;
        OFF_WB_END:   next_wbEnd   = pwdata;
        OFF_BT_INDEX: next_btIdx   = pwdata[PW-1:0];
        default:      next_ctrl    = ctrl;
      endcase
    end
    // Halt is sticky; a new hit wins over a clear in the same cycle.
    next_haltReq = (|seqHit)
                   || (haltReq && !(wrEn && paddr == OFF_STATUS && pwdata[ST_HALT]));
  end

  // Register file and halt registers.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
      ctrl    <= CTRL_RESET;
      waStart <= '0;
      waEnd   <= '0;
      wbStart <= '0;
      wbEnd   <= '0;
      btIdx   <= '0;
      haltReq <= 1'b0;
    end
    else
    begin
      pready  <= next_pready;
      pslverr <= next_pslverr;
      prdata  <= next_prdata;
      ctrl    <= next_ctrl;
      waStart <= next_waStart;
      waEnd   <= next_waEnd;
      wbStart <= next_wbStart;
      wbEnd   <= next_wbEnd;
      btIdx   <= next_btIdx;
      haltReq <= next_haltReq;
    end
  end

  property p_halt;
    @(posedge clk) disable iff (!rstn) |seqHit |=> haltReq;
  endproperty
  a_halt: assert property (p_halt) else $error("Sequence hit did not halt.");

  property p_rt_nostall;
    @(posedge clk) disable iff (!rstn) !nonRt |=> !cpuStall;
  endproperty
  a_rt_nostall: assert property (p_rt_nostall) else $error("Realtime mode stalled.");

  property p_rt_drop;
    @(posedge clk) disable iff (!rstn)
      !nonRt && branchValid && brEn && auxValid && !auxReady |=> dropFlag && auxType == $past(auxType);
  endproperty
  a_rt_drop: assert property (p_rt_drop) else $error("Busy branch not dropped.");

  property p_nrt_stall;
    @(posedge clk) disable iff (!rstn)
      nonRt && branchValid && brEn && auxValid && !auxReady |=> cpuStall && auxValid;
  endproperty
  a_nrt_stall: assert property (p_nrt_stall) else $error("Busy branch did not stall.");

  property p_hold;
    @(posedge clk) disable iff (!rstn) auxValid && !auxReady |=> auxValid && $stable(auxData);
  endproperty
  a_hold: assert property (p_hold) else $error("Record changed before taken.");

  property p_branch;
    @(posedge clk) disable iff (!rstn)
      slotFree && branchValid && brEn |=> auxType == AUX_BRANCH && auxData == {$past(branchDst), $past(branchSrc)};
  endproperty
  a_branch: assert property (p_branch) else $error("Branch record wrong.");

  property p_win;
    @(posedge clk) disable iff (!rstn)
      slotFree && !branchGo && winAHit |=> auxValid && auxType == AUX_WIN_A;
  endproperty
  a_win: assert property (p_win) else $error("Window A access not traced.");

  property p_sw;
    @(posedge clk) disable iff (!rstn)
      slotFree && !branchGo && !winAHit && !winBHit && swHit |=> auxType == AUX_SW
        && auxData == {$past(swTraceReg), $past(swTracePc)};
  endproperty
  a_sw: assert property (p_sw) else $error("Software trace record wrong.");

  property p_count;
    @(posedge clk) disable iff (!rstn) btCount <= CW'(BT_DEPTH) && (cont || btCount <= CW'(BT_BASE));
  endproperty
  a_count: assert property (p_count) else $error("Branch store overfilled.");

  c_halt:  cover property (@(posedge clk) disable iff (!rstn) seqHit[3]);
  c_drop:  cover property (@(posedge clk) disable iff (!rstn) $rose(dropFlag));
  c_stall: cover property (@(posedge clk) disable iff (!rstn) cpuStall ##1 !cpuStall);
endmodule

// >>> verif/sbt_probe_model.sv
// Probe model that takes aux trace port records into a small trace buffer.
module sbt_probe_model
  import sbt_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rstn,
  input  wire logic              hold,
  input  wire logic              stopMode,
  input  wire logic              auxValid,
  input  wire sbt_aux_t          auxType,
  input  wire sbt_len_t          auxLen,
  input  wire logic [2*DATA_W-1:0] auxData,
  output logic                   auxReady,
  output int                     recCount,
  output sbt_aux_t               lastType,
  output sbt_len_t               lastLen,
  output logic [2*DATA_W-1:0]    lastData
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [2*DATA_W-1:0] buffer [4];
  int                  fill;
  int                  wrPtr;
  // The probe sits on the port and takes a record unless told to stall.
  assign auxReady = ~hold;
  // Records land in the buffer; when it is full it either overwrites or stops.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      recCount <= 0;
      fill <= 0;
      wrPtr <= 0;
    end
    else if (auxValid && auxReady)
    begin
      recCount <= recCount + 1;
      lastType <= auxType;
      lastLen <= auxLen;
      lastData <= auxData;
      if (fill < 4 || !stopMode)
      begin
        buffer[wrPtr] <= auxData;
        wrPtr <= (wrPtr + 1) % 4;
        fill <= (fill < 4) ? fill + 1 : fill;
      end
    end
  end
endmodule

// >>> verif/sbt_debug_top_bench.sv
// Self-checking testbench for the sequential break and trace capture block.
module sbt_debug_top_bench
  import sbt_pkg::*;
();
  timeunit 1ns;
  timeprecision 100ps;
  logic            clk = 1'h0, rstn = 1'h0, hold = 1'h0, stopMode = 1'h0;
  logic            psel = 1'h0, penable = 1'h0, pwrite = 1'h0, branchValid = 1'h0;
  logic            busValid = 1'h0, busWrite = 1'h0, swTraceValid = 1'h0, ioValid = 1'h0, tlbLoadValid = 1'h0;
  logic [7:0]      paddr = 8'h00;
  logic [5:0]      cv = 6'h00;
  logic [31:0]     pwdata = 32'h0, branchSrc = 32'h0, branchDst = 32'h0, busAddr = 32'h0, busData = 32'h0;
  logic [31:0]     swTracePc = 32'h0, swTraceReg = 32'h0, ioAddr = 32'h0, ioData = 32'h0, tlbLoadPc = 32'h0;
  logic [31:0]     prdata, rd;
  logic            pready, pslverr, haltReq, cpuStall, auxValid, auxReady, e;
  sbt_aux_t        auxType, lastType;
  sbt_len_t        auxLen, lastLen;
  logic [63:0]     auxData, lastData;
  int              recCount, n0, err_count = 0, tests_run = 0;
  logic [31:0]     srcs [4] = '{32'h1234_567C, 32'h1234_56A0, 32'h1234_9000, 32'hABCD_0000};
  sbt_len_t        lens [4] = '{LEN_4, LEN_8, LEN_16, LEN_32};

  sbt_debug_top i_sbt_debug_top (
    .clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .brkCond(cv[3:0]),
    .userBreakCond(cv[5:4]), .branchValid(branchValid), .branchSrc(branchSrc), .branchDst(branchDst),
    .busValid(busValid), .busWrite(busWrite), .busAddr(busAddr), .busData(busData),
    .swTraceValid(swTraceValid), .swTracePc(swTracePc), .swTraceReg(swTraceReg), .ioValid(ioValid),
    .ioAddr(ioAddr), .ioData(ioData), .tlbLoadValid(tlbLoadValid), .tlbLoadPc(tlbLoadPc),
    .auxReady(auxReady), .haltReq(haltReq), .cpuStall(cpuStall), .auxValid(auxValid),
    .auxType(auxType), .auxLen(auxLen), .auxData(auxData));
  sbt_probe_model i_sbt_probe_model (
    .clk(clk), .rstn(rstn), .hold(hold), .stopMode(stopMode), .auxValid(auxValid), .auxType(auxType),
    .auxLen(auxLen), .auxData(auxData), .auxReady(auxReady), .recCount(recCount), .lastType(lastType),
    .lastLen(lastLen), .lastData(lastData));

  // Clock at 250 MHz.
  always #2 clk = ~clk;

  // Compares one value and reports a mismatch at once.
  task automatic chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      err_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One APB transfer; it holds the request until pready is seen high.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    @(posedge clk);
    while (pready !== 1'h1) @(posedge clk);
    rd = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'h1, a, d);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'h0, a, 32'h0);
    chk("register", rd, exp);
  endtask

  // Raises one break condition for a single cycle.
  task automatic pulse(input int i);
    @(posedge clk) cv <= 6'h01 << i;
    @(posedge clk) cv <= 6'h00;
  endtask

  // Presents one branch for a cycle, then waits one cycle more whether or not the probe is ready.
  task automatic send_branch(input logic [31:0] s, input logic [31:0] d);
    @(posedge clk);
    branchValid <= 1'h1;
    branchSrc <= s;
    branchDst <= d;
    @(posedge clk) branchValid <= 1'h0;
    @(posedge clk);
    #1;
  endtask

  // One bus cycle, then checks whether a window record came out.
  task automatic bus_chk(input logic w, input logic [31:0] a, input int n, input sbt_aux_t t);
    n0 = recCount;
    @(posedge clk);
    busValid <= 1'h1;
    busWrite <= w;
    busAddr <= a;
    busData <= ~a;
    @(posedge clk) busValid <= 1'h0;
    @(posedge clk);
    #1;
    chk("window count", recCount - n0, n);
    if (n == 1)
    begin
      chk("window type", lastType, t);
      chk("window data", lastData, {~a, a});
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic end_sim();
    $display("Checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Cuts a hang short.
  initial
  begin
    #100000;
    err_count++;
    end_sim();
  end

  // Main sequence of tests.
  initial
  begin
    repeat (2) @(posedge clk);
    rstn <= 1'h1;
    #1 chk("auxLen reset", auxLen, LEN_32);
    rdchk(OFF_CTRL, 32'(CTRL_RESET));
    rdchk(OFF_STATUS, 32'h0);
    apb(1'h0, 8'hFC, 32'h0);
    chk("pslverr", e, 1'h1);
    for (int k = 0; k < SEQ_N; k++)
    begin
      wr(OFF_CTRL, 32'h1 << k);
      for (int i = SEQ_LO[k]; i <= SEQ_HI[k]; i++) pulse(i);
      #1 chk("halt wrong order", haltReq, 1'h0);
      wr(OFF_CTRL, 32'h0);
      wr(OFF_CTRL, 32'h1 << k);
      for (int i = SEQ_HI[k] - 1; i >= SEQ_LO[k]; i--) pulse(i);
      for (int i = SEQ_HI[k]; i >= SEQ_LO[k]; i--)
      begin
        #1 chk("halt early", haltReq, 1'h0);
        pulse(i);
      end
      #1 chk("halt", haltReq, 1'h1);
      wr(OFF_STATUS, 32'h1);
      #1 chk("halt clear", haltReq, 1'h0);
    end
    wr(OFF_CTRL, 32'h1 << CTRL_BR_EN);
    hold <= 1'h1;
    n0 = recCount;
    send_branch(32'h1234_5670, 32'h0000_1000);
    send_branch(32'h1234_567C, 32'h0000_2000);
    chk("stall realtime", cpuStall, 1'h0);
    @(posedge clk) hold <= 1'h0;
    repeat (2) @(posedge clk);
    #1 chk("realtime count", recCount - n0, 1);
    chk("realtime data", lastData, {32'h0000_1000, 32'h1234_5670});
    rdchk(OFF_STATUS, 32'h2);
    wr(OFF_STATUS, 32'h2);
    rdchk(OFF_STATUS, 32'h0);
    for (int k = 0; k < 4; k++)
    begin
      send_branch(srcs[k], ~srcs[k]);
      chk("auxLen", lastLen, lens[k]);
      chk("branch data", lastData, {~srcs[k], srcs[k]});
    end
    wr(OFF_CTRL, (32'h1 << CTRL_BR_EN) | (32'h1 << CTRL_NONRT));
    hold <= 1'h1;
    n0 = recCount;
    send_branch(32'h0000_0100, 32'h0000_0200);
    @(posedge clk);
    branchValid <= 1'h1;
    branchSrc <= 32'h0000_0300;
    branchDst <= 32'h0000_0400;
    repeat (2) @(posedge clk);
    #1 chk("stall", cpuStall, 1'h1);
    @(posedge clk) hold <= 1'h0;
    @(posedge clk) branchValid <= 1'h0;
    repeat (2) @(posedge clk);
    #1 chk("stall count", recCount - n0, 2);
    chk("stall data", lastData, {32'h0000_0400, 32'h0000_0300});
    chk("stall end", cpuStall, 1'h0);
    wr(OFF_WA_START, 32'h0000_1000);
    wr(OFF_WA_END, 32'h0000_10FF);
    wr(OFF_WB_START, 32'h0000_2000);
    wr(OFF_WB_END, 32'h0000_2003);
    wr(OFF_CTRL, (32'h1 << CTRL_WA_EN) | (32'h1 << CTRL_WB_EN) | (32'h1 << CTRL_WA_MODE) | (32'h2 << CTRL_WB_MODE));
    bus_chk(1'h0, 32'h0000_1000, 1, AUX_WIN_A);
    bus_chk(1'h0, 32'h0000_10FF, 1, AUX_WIN_A);
    bus_chk(1'h0, 32'h0000_1100, 0, AUX_WIN_A);
    bus_chk(1'h0, 32'h0000_0FFF, 0, AUX_WIN_A);
    bus_chk(1'h1, 32'h0000_1000, 0, AUX_WIN_A);
    bus_chk(1'h1, 32'h0000_2003, 1, AUX_WIN_B);
    bus_chk(1'h0, 32'h0000_2000, 0, AUX_WIN_B);
    wr(OFF_CTRL, (32'h1 << CTRL_WA_EN) | (32'h3 << CTRL_WA_MODE) | (32'h2 << CTRL_WB_MODE));
    bus_chk(1'h1, 32'h0000_1050, 1, AUX_WIN_A);
    bus_chk(1'h0, 32'h0000_1050, 1, AUX_WIN_A);
    bus_chk(1'h1, 32'h0000_2000, 0, AUX_WIN_B);
    wr(OFF_CTRL, 32'h1 << CTRL_SW_EN);
    @(posedge clk);
    swTraceValid <= 1'h1;
    swTracePc <= 32'h0000_8000;
    swTraceReg <= 32'hCAFE_0001;
    @(posedge clk) swTraceValid <= 1'h0;
    @(posedge clk);
    #1 chk("sw type", lastType, AUX_SW);
    chk("sw data", lastData, {32'hCAFE_0001, 32'h0000_8000});
    wr(OFF_CTRL, 32'h1 << CTRL_CONT);
    n0 = recCount;
    @(posedge clk);
    ioValid <= 1'h1;
    ioAddr <= 32'h0000_0A10;
    ioData <= 32'h5A5A_0001;
    tlbLoadValid <= 1'h1;
    tlbLoadPc <= 32'h0000_0C20;
    @(posedge clk);
    ioValid <= 1'h0;
    tlbLoadValid <= 1'h0;
    repeat (2) @(posedge clk);
    #1 chk("internal only", recCount - n0, 0);
    rdchk(OFF_IO_ADDR, 32'h0000_0A10);
    rdchk(OFF_IO_DATA, 32'h5A5A_0001);
    rdchk(OFF_TLB_PC, 32'h0000_0C20);
    wr(OFF_CTRL, 32'h1 << CTRL_BR_EN);
    for (int k = 0; k < 9; k++) send_branch(32'h0000_4000 + 32'(k), 32'h0000_5000);
    rdchk(OFF_BT_COUNT, 32'h8);
    stopMode <= 1'h1;
    wr(OFF_CTRL, (32'h1 << CTRL_BR_EN) | (32'h1 << CTRL_NONRT) | (32'h1 << CTRL_CONT) | (32'h1 << CTRL_STOP));
    for (int k = 0; k < 33; k++) send_branch(32'h0000_6000 + 32'(k), 32'h0000_7000);
    rdchk(OFF_BT_COUNT, 32'h20);
    apb(1'h0, OFF_STATUS, 32'h0);
    chk("store full", rd[ST_FULL], 1'h1);
    wr(OFF_BT_INDEX, 32'h0);
    rdchk(OFF_BT_SRC, 32'h0000_4008);
    rdchk(OFF_BT_DST, 32'h0000_5000);
    end_sim();
  end
endmodule
